// *** usbv_pkg.sv ***
// How it works
// [RQ1] Latch two mode straps, select chip mode.
// [RQ2] ROM mode drives ROM select, address, data.
// [RQ3] Capture vendor and product identifiers at reset.
// [RQ4] Strapped peripherals float their outputs during reset.
// [RQ5] Product bits 15:14 pick descriptor set.
// [RQ6] Product bits 13:12 set maximum power.
// [RQ7] Product bit 11 enables remote wake-up.
// [RQ8] Product bit 10 picks audio codec channel.
// [RQ9] Product bit 9 picks audio shift order.
// [RQ10] Product bit 8 inverts audio data clock.
// [RQ11] Product bits 7:6 set clock doubler delay.
// [RQ12] Product bit 5 sets suspend output polarity.
// [RQ13] Product bit 4 enables clock multiplier.
// [RQ14] Product bits 3:2 force serial pads input.
// [RQ15] ROM mode still applies product bits 15:2.
// [RQ16] Request type bit 7 gives transfer direction.
// [RQ17] Request bit 0 holds or increments address.
// [RQ18] Request bits 2:1 set strobe width.
// [RQ19] Request bit 3 checks masked status first.
// [RQ20] Failed check halts, records completed operation count.
// [RQ21] Index below 0xC0 internal, above peripheral.
// [RQ22] Count byte gives transfers, maximum attempts.
package usbv_pkg;

  // ----------------------------------------------------------------
  // Chip modes and strap timing
  // ----------------------------------------------------------------
  localparam logic [1:0] MODE_LEGACY = 2'h0;
  localparam logic [1:0] MODE_AUDIO = 2'h1;
  localparam logic [1:0] MODE_TEST = 2'h2;
  localparam logic [1:0] MODE_ROM = 2'h3;
  localparam logic [1:0] STRAP_SYNC_CYC = 2'h3;
  localparam int SYNC_W = 37;

  // ----------------------------------------------------------------
  // Product identifier fields
  // ----------------------------------------------------------------
  localparam int PID_DESC_LO = 14;
  localparam int PID_POWER_LO = 12;
  localparam int PID_WAKE = 11;
  localparam int PID_CHAN = 10;
  localparam int PID_LSB = 9;
  localparam int PID_CLK_INV = 8;
  localparam int PID_DBL_LO = 6;
  localparam int PID_SUSP_HI = 5;
  localparam int PID_PLL = 4;
  localparam int PID_BCLK_IN = 3;
  localparam int PID_FSYNC_IN = 2;
  localparam logic [9:0] POWER_MA_0 = 10'h1F4;
  localparam logic [9:0] POWER_MA_1 = 10'h190;
  localparam logic [9:0] POWER_MA_2 = 10'h12C;
  localparam logic [9:0] POWER_MA_3 = 10'h0FA;
  localparam logic [5:0] DBL_NS_0 = 6'h00;
  localparam logic [5:0] DBL_NS_1 = 6'h1E;
  localparam logic [5:0] DBL_NS_2 = 6'h28;
  localparam logic [5:0] DBL_NS_3 = 6'h32;

  // ----------------------------------------------------------------
  // Vendor command fields and address map
  // ----------------------------------------------------------------
  localparam int REQ_DIR_BIT = 7;
  localparam int REQ_HOLD_BIT = 0;
  localparam int REQ_WID_LO = 1;
  localparam int REQ_CHK_BIT = 3;
  localparam logic [1:0] PERIPH_REGION = 2'h3;
  localparam logic [7:0] REG_OPS_A = 8'h05;
  localparam logic [7:0] REG_OPS_B = 8'h06;

  // ----------------------------------------------------------------
  // Strobe widths, given in system cycles, turned into clock counts
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 10000;
  localparam int SYS_CYC_PS = 41667;
  localparam int STB_SYS_0 = 2;
  localparam int STB_SYS_1 = 3;
  localparam int STB_SYS_2 = 8;
  localparam int STB_SYS_3 = 16;
  localparam int STB_CYC_0 =
    (STB_SYS_0 * SYS_CYC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STB_CYC_1 =
    (STB_SYS_1 * SYS_CYC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STB_CYC_2 =
    (STB_SYS_2 * SYS_CYC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int STB_CYC_3 =
    (STB_SYS_3 * SYS_CYC_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ACC = 6'h02,
    ST_WAIT_WR = 6'h04,
    ST_RD_OUT = 6'h08,
    ST_STEP = 6'h10,
    ST_FIN = 6'h20
  } usbv_state_e;

endpackage

// *** usbv_cmd.sv ***
`timescale 1ns/1ps
module usbv_cmd (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [5:0] periph_addr_i,
  output logic [5:0] periph_addr_o,
  output logic periph_addr_oe_o,
  input wire logic [7:0] periph_data_i,
  output logic [7:0] periph_data_o,
  output logic periph_data_oe_o,
  output logic periph_read_n_o,
  output logic periph_write_n_o,
  input wire logic [7:0] mem_data_i,
  input wire logic [14:0] mem_addr_i,
  output logic [14:0] mem_addr_o,
  output logic mem_addr_oe_o,
  input wire logic rom_req_i,
  input wire logic [9:0] rom_address_i,
  output logic rom_chip_select_n_o,
  output logic [7:0] rom_data_o,
  input wire logic suspend_i,
  output logic suspend_pin_o,
  output logic strap_done_o,
  output logic [1:0] chip_mode_o,
  output logic test_mode_o,
  output logic [15:0] vendor_id_o,
  output logic [15:0] product_id_o,
  output logic settings_valid_o,
  output logic [1:0] descriptor_set_o,
  output logic [9:0] max_power_ma_o,
  output logic remote_wakeup_en_o,
  output logic audio_channel_o,
  output logic audio_lsb_first_o,
  output logic audio_clk_invert_o,
  output logic [1:0] clk_doubler_o,
  output logic [5:0] doubler_delay_ns_o,
  output logic pll_enable_o,
  output logic serial_bit_clock_force_in_o,
  output logic frame_sync_force_in_o,
  input wire logic cmd_valid_i,
  output logic cmd_ready_o,
  input wire logic [7:0] cmd_req_type_i,
  input wire logic [7:0] cmd_request_i,
  input wire logic [15:0] cmd_value_i,
  input wire logic [15:0] cmd_index_i,
  input wire logic [15:0] cmd_count_i,
  input wire logic wr_valid_i,
  output logic wr_ready_o,
  input wire logic [7:0] wr_data_i,
  output logic rd_valid_o,
  input wire logic rd_ready_i,
  output logic [7:0] rd_data_o,
  output logic done_o,
  output logic check_failed_o,
  output logic [7:0] reg_addr_o,
  output logic reg_rd_o,
  output logic reg_wr_o,
  output logic [7:0] reg_wdata_o,
  input wire logic [7:0] reg_rdata_i
);
  import usbv_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers and strap capture
  // ----------------------------------------------------------------
  logic [SYNC_W-1:0] sync1_r, sync2_r;
  logic [5:0] periph_addr_s;
  logic [7:0] periph_data_s, mem_data_s;
  logic [14:0] mem_addr_s;
  logic [1:0] cap_cnt_r, chip_mode_r;
  logic strap_done_r, set_ok, rom_mode, acc_wr;
  logic [15:0] vendor_id_r, product_id_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else if (ce_i) begin
      sync1_r <= {periph_addr_i, periph_data_i, mem_data_i, mem_addr_i};
      sync2_r <= sync1_r;
    end
  end

  assign {periph_addr_s, periph_data_s, mem_data_s, mem_addr_s} = sync2_r;

  // Straps are caught from samples synchronised after the release.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cap_cnt_r <= '0;
      strap_done_r <= 1'b0;
      chip_mode_r <= MODE_LEGACY;
      vendor_id_r <= '0;
      product_id_r <= '0;
    end else if (ce_i && !strap_done_r) begin
      if (cap_cnt_r == STRAP_SYNC_CYC) begin
        strap_done_r <= 1'b1;
        chip_mode_r <= periph_addr_s[3:2]; // see [RQ1]
        vendor_id_r <= {periph_data_s, mem_data_s}; // see [RQ3]
        product_id_r <= {periph_addr_s[0], mem_addr_s}; // see [RQ3]
      end else begin
        cap_cnt_r <= cap_cnt_r + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Settings decoded from the product identifier
  // ----------------------------------------------------------------
  // Settings hold in audio mode and in ROM mode.
  assign set_ok = strap_done_r &&
    (chip_mode_r == MODE_AUDIO || chip_mode_r == MODE_ROM); // see [RQ15]
  assign strap_done_o = strap_done_r;
  assign chip_mode_o = chip_mode_r;
  assign test_mode_o = strap_done_r && chip_mode_r == MODE_TEST;
  assign vendor_id_o = vendor_id_r;
  assign product_id_o = product_id_r;
  assign settings_valid_o = set_ok;
  assign descriptor_set_o = product_id_r[PID_DESC_LO+:2]; // see [RQ5]
  assign remote_wakeup_en_o = set_ok && product_id_r[PID_WAKE]; // see [RQ7]
  assign audio_channel_o = set_ok && product_id_r[PID_CHAN]; // see [RQ8]
  assign audio_lsb_first_o = set_ok && product_id_r[PID_LSB]; // see [RQ9]
  assign audio_clk_invert_o =
    set_ok && product_id_r[PID_CLK_INV]; // see [RQ10]
  assign clk_doubler_o =
    set_ok ? product_id_r[PID_DBL_LO+:2] : 2'h0; // see [RQ11]
  assign pll_enable_o = set_ok && product_id_r[PID_PLL]; // see [RQ13]
  assign serial_bit_clock_force_in_o =
    set_ok && product_id_r[PID_BCLK_IN]; // see [RQ14]
  assign frame_sync_force_in_o =
    set_ok && product_id_r[PID_FSYNC_IN]; // see [RQ14]

  always_comb begin
    unique case (product_id_r[PID_POWER_LO+:2]) // see [RQ6]
      2'h0: max_power_ma_o = POWER_MA_0;
      2'h1: max_power_ma_o = POWER_MA_1;
      2'h2: max_power_ma_o = POWER_MA_2;
      2'h3: max_power_ma_o = POWER_MA_3;
    endcase
    unique case (clk_doubler_o) // see [RQ11]
      2'h0: doubler_delay_ns_o = DBL_NS_0;
      2'h1: doubler_delay_ns_o = DBL_NS_1;
      2'h2: doubler_delay_ns_o = DBL_NS_2;
      2'h3: doubler_delay_ns_o = DBL_NS_3;
    endcase
  end

  // Suspend shows active low unless the strap asks for active high.
  assign suspend_pin_o = (set_ok && product_id_r[PID_SUSP_HI]) ?
    suspend_i : !suspend_i; // see [RQ12]

  // ----------------------------------------------------------------
  // External descriptor ROM
  // ----------------------------------------------------------------
  assign rom_mode = strap_done_r && chip_mode_r == MODE_ROM;
  assign rom_chip_select_n_o = !(rom_mode && rom_req_i); // see [RQ2]
  // The memory address bus floats except in ROM mode after capture, so the pulls set what is read.
  assign mem_addr_oe_o = rom_mode; // see [RQ4]
  assign mem_addr_o = {5'h00, rom_address_i}; // see [RQ2]

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rom_data_o <= '0;
    end else if (ce_i && rom_mode) begin
      rom_data_o <= mem_data_s; // see [RQ2]
    end
  end

  // ----------------------------------------------------------------
  // Vendor command engine
  // ----------------------------------------------------------------
  usbv_state_e state_r, state_nxt;
  logic dir_rd_r, hold_r, chk_r, acc_chk_r, fail_r, acc_periph, acc_last;
  logic acc_first, chk_pass, last_op, go_acc, go_chk;
  logic [6:0] width_r, width_nxt, acc_cnt_r;
  logic [7:0] stat_addr_r, mask_r, addr_r, count_r, ops_r, acc_addr_r;
  logic [7:0] data_r, ops_a_r, ops_b_r, acc_val;

  always_comb begin
    unique case (cmd_request_i[REQ_WID_LO+:2]) // see [RQ18]
      2'h0: width_nxt = 7'(STB_CYC_0);
      2'h1: width_nxt = 7'(STB_CYC_1);
      2'h2: width_nxt = 7'(STB_CYC_2);
      2'h3: width_nxt = 7'(STB_CYC_3);
    endcase
  end

  assign acc_periph = acc_addr_r[7:6] == PERIPH_REGION; // see [RQ21]
  assign acc_last = state_r == ST_ACC && acc_cnt_r == 7'h01;
  assign acc_first = state_r == ST_ACC && acc_cnt_r == width_r;
  assign acc_val = acc_periph ? periph_data_s :
    acc_addr_r == REG_OPS_A ? ops_a_r :
    acc_addr_r == REG_OPS_B ? ops_b_r : reg_rdata_i;
  assign chk_pass = (acc_val & mask_r) != 8'h00; // see [RQ19]
  assign last_op = ops_r == count_r; // see [RQ22]

  // Next step after a transfer or at command start.
  always_comb begin
    state_nxt = state_r;
    go_acc = 1'b0;
    go_chk = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        if (cmd_valid_i && strap_done_r) begin
          state_nxt = ST_STEP;
        end
      end
      ST_STEP: begin
        if (last_op || fail_r) begin
          state_nxt = ST_FIN;
        end else if (chk_r) begin
          state_nxt = ST_ACC;
          go_chk = 1'b1;
        end else if (!dir_rd_r) begin
          state_nxt = ST_WAIT_WR;
        end else begin
          state_nxt = ST_ACC;
          go_acc = 1'b1;
        end
      end
      ST_WAIT_WR: begin
        if (wr_valid_i || dir_rd_r) begin
          state_nxt = ST_ACC;
          go_acc = 1'b1;
        end
      end
      ST_ACC: begin
        if (acc_last) begin
          if (acc_chk_r && !chk_pass) begin
            state_nxt = ST_STEP;
          end else if (acc_chk_r) begin
            state_nxt = ST_WAIT_WR;
          end else if (dir_rd_r) begin
            state_nxt = ST_RD_OUT;
          end else begin
            state_nxt = ST_STEP;
          end
        end
      end
      ST_RD_OUT: begin
        if (rd_ready_i) begin
          state_nxt = ST_STEP;
        end
      end
      ST_FIN: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= ST_IDLE;
    end else if (ce_i) begin
      state_r <= state_nxt;
    end
  end

  // A new command is only taken in idle; that is also what lifts a halt.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dir_rd_r <= 1'b0;
      hold_r <= 1'b0;
      chk_r <= 1'b0;
      width_r <= 7'(STB_CYC_0);
      stat_addr_r <= '0;
      mask_r <= '0;
      count_r <= '0;
    end else if (ce_i && state_r == ST_IDLE && cmd_valid_i &&
                 strap_done_r) begin
      dir_rd_r <= cmd_req_type_i[REQ_DIR_BIT]; // see [RQ16]
      hold_r <= cmd_request_i[REQ_HOLD_BIT]; // see [RQ17]
      chk_r <= cmd_request_i[REQ_CHK_BIT]; // see [RQ19]
      width_r <= width_nxt; // see [RQ18]
      stat_addr_r <= cmd_value_i[7:0]; // see [RQ19]
      mask_r <= cmd_value_i[15:8]; // see [RQ19]
      count_r <= cmd_count_i[7:0]; // see [RQ22]
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_r <= '0;
      ops_r <= '0;
      fail_r <= 1'b0;
    end else if (ce_i) begin
      if (state_r == ST_IDLE && cmd_valid_i && strap_done_r) begin
        addr_r <= cmd_index_i[7:0]; // see [RQ21]
        ops_r <= '0;
        fail_r <= 1'b0;
      end else if (acc_last && acc_chk_r && !chk_pass) begin
        fail_r <= 1'b1; // see [RQ20]
      end else if (acc_last && !acc_chk_r) begin
        ops_r <= ops_r + 8'h01;
        if (!hold_r) begin
          addr_r <= addr_r + 8'h01; // see [RQ17]
        end
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_addr_r <= '0;
      acc_chk_r <= 1'b0;
      acc_cnt_r <= '0;
    end else if (ce_i) begin
      if (go_chk) begin
        acc_addr_r <= stat_addr_r; // see [RQ19]
        acc_chk_r <= 1'b1;
        acc_cnt_r <= width_r;
      end else if (go_acc) begin
        acc_addr_r <= addr_r;
        acc_chk_r <= 1'b0;
        acc_cnt_r <= width_r;
      end else if (state_r == ST_ACC) begin
        acc_cnt_r <= acc_cnt_r - 7'h01; // see [RQ18]
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_r <= '0;
    end else if (ce_i) begin
      if (state_r == ST_WAIT_WR && wr_valid_i && !dir_rd_r) begin
        data_r <= wr_data_i;
      end else if (acc_last && !acc_chk_r && dir_rd_r) begin
        data_r <= acc_val;
      end
    end
  end

  // Reads log their count in the first register, writes in the second.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ops_a_r <= '0;
      ops_b_r <= '0;
    end else if (ce_i && state_r == ST_STEP && (last_op || fail_r)) begin
      if (dir_rd_r) begin
        ops_a_r <= ops_r; // see [RQ20]
      end else begin
        ops_b_r <= ops_r; // see [RQ20]
      end
    end
  end

  // ----------------------------------------------------------------
  // Strobes and host side handshakes
  // ----------------------------------------------------------------
  assign acc_wr = state_r == ST_ACC && !acc_chk_r && !dir_rd_r;
  assign periph_addr_oe_o = strap_done_r; // see [RQ4]
  assign periph_addr_o = acc_addr_r[5:0]; // see [RQ21]
  assign periph_data_o = data_r;
  assign periph_data_oe_o = acc_wr && acc_periph;
  assign periph_read_n_o = !(state_r == ST_ACC && acc_periph &&
    (acc_chk_r || dir_rd_r)); // see [RQ21]
  assign periph_write_n_o = !(acc_wr && acc_periph); // see [RQ21]
  assign reg_addr_o = acc_addr_r;
  assign reg_wdata_o = data_r;
  assign reg_rd_o = acc_first && !acc_periph && !acc_wr;
  // The count registers are read only, so writes to them go nowhere.
  assign reg_wr_o = acc_first && !acc_periph && acc_wr &&
    acc_addr_r != REG_OPS_A && acc_addr_r != REG_OPS_B;
  assign cmd_ready_o = state_r == ST_IDLE && strap_done_r;
  assign wr_ready_o = state_r == ST_WAIT_WR && !dir_rd_r;
  assign rd_valid_o = state_r == ST_RD_OUT;
  assign rd_data_o = data_r;
  assign done_o = state_r == ST_FIN;
  assign check_failed_o = fail_r;

endmodule // usbv_cmd

// *** usbv_cmd_chk_asserts.sv ***
`timescale 1ns/1ps
module usbv_cmd_chk
  import usbv_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic [5:0] periph_addr_i,
  input wire logic periph_read_n_o,
  input wire logic periph_write_n_o,
  input wire logic [7:0] periph_data_i,
  input wire logic [7:0] mem_data_i,
  input wire logic [14:0] mem_addr_i,
  input wire logic rom_req_i,
  input wire logic rom_chip_select_n_o,
  input wire logic suspend_i,
  input wire logic suspend_pin_o,
  input wire logic strap_done_o,
  input wire logic [1:0] chip_mode_o,
  input wire logic [15:0] vendor_id_o,
  input wire logic [15:0] product_id_o,
  input wire logic settings_valid_o,
  input wire logic [9:0] max_power_ma_o,
  input wire logic cmd_valid_i,
  input wire logic cmd_ready_o,
  input wire logic [7:0] cmd_request_i,
  input wire logic [15:0] cmd_index_i,
  input wire logic [15:0] cmd_count_i,
  input wire logic done_o,
  input wire logic check_failed_o,
  input wire logic [7:0] reg_addr_o,
  input wire logic reg_rd_o,
  input wire logic reg_wr_o
);
  // ------------
  // Helper state
  // ------------
  logic stb, take, pa0, hold_r, chk_r;
  logic [1:0] mode_pins, wid_r;
  logic [7:0] idx_r, cnt_r;
  int w_exp;
  assign stb = !periph_read_n_o || !periph_write_n_o;
  assign take = cmd_valid_i && cmd_ready_o;
  assign pa0 = periph_addr_i[0];
  assign mode_pins = periph_addr_i[3:2];
  assign w_exp = (wid_r == 2'h0) ? STB_CYC_0 : (wid_r == 2'h1) ? STB_CYC_1 :
                 (wid_r == 2'h2) ? STB_CYC_2 : STB_CYC_3;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      hold_r <= 1'b0;
      chk_r <= 1'b0;
      wid_r <= 2'h0;
      idx_r <= 8'h00;
    end else if (take) begin
      hold_r <= cmd_request_i[REQ_HOLD_BIT];
      chk_r <= cmd_request_i[REQ_CHK_BIT];
      wid_r <= cmd_request_i[2:1];
      idx_r <= cmd_index_i[7:0];
    end
  end
  // No strobe reaches 255 cycles, so the count never wraps.
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= stb ? cnt_r + 8'h01 : 8'h00;
    end
  end
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  a_strobe_excl: assert property (periph_read_n_o || periph_write_n_o)
    else $error("strobes overlap");
  a_strobe_width: assert property ($fell(stb) |-> cnt_r == w_exp)
    else $error("strobe width");
  a_int_region: assert property (reg_rd_o || reg_wr_o |-> !reg_addr_o[7] || !reg_addr_o[6])
    else $error("internal range");
  a_hold_addr: assert property ((reg_rd_o || reg_wr_o) && hold_r && !chk_r
    |-> reg_addr_o == idx_r) else $error("held address");
  a_zero_count: assert property (take && cmd_count_i[7:0] == 8'h00 |-> ##2 done_o)
    else $error("empty command");
  a_halt_fail: assert property (check_failed_o |-> !stb)
    else $error("after fail");
  a_strap_ids: assert property ($rose(strap_done_o) |->
    vendor_id_o == {$past(periph_data_i), $past(mem_data_i)} &&
    product_id_o == {$past(pa0), $past(mem_addr_i)}) else $error("ids wrong");
  a_mode_latch: assert property ($rose(strap_done_o) |-> chip_mode_o == $past(mode_pins))
    else $error("chip mode");
  a_rom_select: assert property (rom_chip_select_n_o ==
    !(strap_done_o && chip_mode_o == MODE_ROM && rom_req_i))
    else $error("rom select");
  a_settings_on: assert property (settings_valid_o == (strap_done_o && chip_mode_o[0]))
    else $error("settings valid");
  a_power_map: assert property (strap_done_o |-> max_power_ma_o ==
    ((product_id_o[13:12] == 2'h0) ? 10'h1F4 : (product_id_o[13:12] == 2'h1)
    ? 10'h190 : (product_id_o[13:12] == 2'h2) ? 10'h12C : 10'h0FA))
    else $error("max power");
  a_suspend_pol: assert property (settings_valid_o |-> suspend_pin_o ==
    (product_id_o[5] ? suspend_i : !suspend_i)) else $error("suspend polarity");
  c_check: cover property (take && cmd_request_i[REQ_CHK_BIT]);
  c_fail: cover property ($rose(check_failed_o));
  c_write: cover property ($fell(periph_write_n_o));
endmodule // usbv_cmd_chk
bind usbv_cmd usbv_cmd_chk i_chk (.*);

// *** usbv_periph_model.sv ***
`timescale 1ns/1ps
module usbv_periph_model (
  input wire logic ref_clk_i,
  input wire logic [7:0] pull_i,
  input wire logic [5:0] pa_i,
  input wire logic [7:0] pd_i,
  input wire logic pd_oe_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] ra_i,
  input wire logic rw_i,
  input wire logic [7:0] rwd_i,
  output logic [7:0] pd_o,
  output logic [7:0] rd_o
);
  // -------------------------------
  // Peripheral and register storage
  // -------------------------------
  logic [7:0] mem [256];
  logic [7:0] pa;
  logic rd_q;
  assign pa = {2'h3, pa_i};
  // An idle bus shows the strap pulls, also in reset.
  assign pd_o = pd_oe_i ? pd_i : !rd_n_i ? mem[pa] : pull_i;
  assign rd_o = mem[ra_i];
  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = i[7:0] ^ 8'h5A;
    end
    mem[8'hFE] = 8'h03;
    rd_q = 1'b1;
  end
  // The status location counts down per read so a check fails mid-run.
  always @(posedge ref_clk_i) begin
    if (rw_i) begin
      mem[ra_i] <= rwd_i;
    end
    if (!wr_n_i && pd_oe_i) begin
      mem[pa] <= pd_i;
    end
    if (!rd_n_i && rd_q && pa == 8'hFE) begin
      mem[pa] <= mem[pa] - 8'h01;
    end
    rd_q <= rd_n_i;
  end
endmodule // usbv_periph_model

// *** test_usb_vendor_cmd_and_strap_config.sv ***
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin errors++; \
  $display("BAD %0t %h %h", $time, (a), (b)); end end
module test_usb_vendor_cmd_and_strap_config;
  import usbv_pkg::*;
  // -------
  // Signals
  // -------
  logic ref_clk_i, rst_n_i, ce_i, periph_addr_oe_o, periph_data_oe_o;
  logic periph_read_n_o, periph_write_n_o, mem_addr_oe_o, rom_req_i;
  logic rom_chip_select_n_o, suspend_i, suspend_pin_o, strap_done_o;
  logic test_mode_o, settings_valid_o, remote_wakeup_en_o, audio_channel_o;
  logic audio_lsb_first_o, audio_clk_invert_o, pll_enable_o;
  logic serial_bit_clock_force_in_o, frame_sync_force_in_o, cmd_valid_i;
  logic cmd_ready_o, wr_valid_i, wr_ready_o, rd_valid_o, rd_ready_i, done_o;
  logic check_failed_o, reg_rd_o, reg_wr_o, sv, done_seen;
  logic [1:0] chip_mode_o, descriptor_set_o, clk_doubler_o, d;
  logic [5:0] periph_addr_i, periph_addr_o, doubler_delay_ns_o, pa_strap;
  logic [7:0] periph_data_i, periph_data_o, mem_data_i, rom_data_o, hd_pull;
  logic [7:0] cmd_req_type_i, cmd_request_i, wr_data_i, rd_data_o;
  logic [7:0] reg_addr_o, reg_wdata_o, reg_rdata_i;
  logic [9:0] rom_address_i, max_power_ma_o;
  logic [14:0] mem_addr_i, mem_addr_o, ma_strap;
  logic [15:0] vendor_id_o, product_id_o, cmd_value_i, cmd_index_i;
  logic [15:0] cmd_count_i, pid, vid;
  logic [7:0] wq [$];
  logic [7:0] rq [$];
  logic [15:0] pid_tab [5] = '{16'h0A29, 16'h5576, 16'hAFBC, 16'hB6CF,
                              16'h4D9B};
  logic [9:0] pw [4] = '{10'h1F4, 10'h190, 10'h12C, 10'h0FA};
  logic [5:0] dl [4] = '{6'h00, 6'h1E, 6'h28, 6'h32};
  int errors, checked, md;
  assign periph_addr_i = periph_addr_oe_o ? periph_addr_o : pa_strap;
  assign mem_addr_i = mem_addr_oe_o ? mem_addr_o : ma_strap;
  usbv_cmd i_dut (.*);
  usbv_periph_model i_model (.ref_clk_i(ref_clk_i), .pull_i(hd_pull),
    .pa_i(periph_addr_o), .pd_i(periph_data_o), .pd_oe_i(periph_data_oe_o),
    .rd_n_i(periph_read_n_o), .wr_n_i(periph_write_n_o), .ra_i(reg_addr_o),
    .rw_i(reg_wr_o), .rwd_i(reg_wdata_o), .pd_o(periph_data_i),
    .rd_o(reg_rdata_i));
  initial begin
    ref_clk_i = 1'b0;
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    if (wr_valid_i && wr_ready_o) begin
      void'(wq.pop_front());
    end
    if (rd_valid_o && rd_ready_i) begin
      rq.push_back(rd_data_o);
    end
    if (done_o) begin
      done_seen = 1'b1;
    end
  end
  // -----
  // Tasks
  // -----
  task automatic print_verdict;
    if (errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // Fields stand until taken; write bytes until accepted.
  task automatic vcmd(input logic [7:0] rt, rb, input logic [15:0] val, ix,
                      input logic [7:0] cnt);
    int n;
    n = 0;
    @(negedge ref_clk_i);
    cmd_valid_i = 1'b1;
    cmd_req_type_i = rt;
    cmd_request_i = rb;
    cmd_value_i = val;
    cmd_index_i = ix;
    cmd_count_i = {8'hA5, cnt};
    rq.delete();
    done_seen = 1'b0;
    while (cmd_ready_o !== 1'b1 && n < 200) begin
      @(negedge ref_clk_i);
      n++;
    end
    @(negedge ref_clk_i);
    cmd_valid_i = 1'b0;
    n = 0;
    while (!done_seen && n < 20000) begin
      wr_valid_i = !rt[7] && wq.size() > 0;
      if (wq.size() > 0) begin
        wr_data_i = wq[0];
      end
      @(negedge ref_clk_i);
      n++;
    end
    wr_valid_i = 1'b0;
    if (!done_seen) begin
      errors++;
    end
  endtask
  // ---------
  // Sequence
  // ---------
  initial begin
    {ce_i, rd_ready_i, suspend_i} = 3'h7;
    {rst_n_i, cmd_valid_i, wr_valid_i, rom_req_i} = 4'h0;
    {cmd_req_type_i, cmd_request_i, wr_data_i, mem_data_i} = 32'h0;
    {cmd_value_i, cmd_index_i, cmd_count_i} = 48'h0;
    {pa_strap, ma_strap, hd_pull} = 29'h0;
    rom_address_i = 10'h2A5;
    for (int m = 0; m < 5; m++) begin
      @(negedge ref_clk_i);
      md = (m > 3) ? 1 : m;
      pid = pid_tab[m];
      vid = 16'hC3A5 ^ {8{md[1:0]}};
      sv = md[0];
      d = sv ? pid[7:6] : 2'h0;
      rst_n_i = 1'b0;
      pa_strap = {2'h0, md[1:0], 1'b0, pid[15]};
      ma_strap = pid[14:0];
      hd_pull = vid[15:8];
      mem_data_i = vid[7:0];
      repeat (16) @(negedge ref_clk_i);
      rst_n_i = 1'b1;
      repeat (8) @(negedge ref_clk_i);
      `CHK({chip_mode_o, test_mode_o}, {md[1:0], md == 2})
      `CHK({vendor_id_o, product_id_o}, {vid, pid})
      `CHK(descriptor_set_o, pid[15:14])
      `CHK(max_power_ma_o, pw[pid[13:12]])
      `CHK({remote_wakeup_en_o, audio_channel_o, audio_lsb_first_o,
            audio_clk_invert_o}, sv ? pid[11:8] : 4'h0)
      `CHK({clk_doubler_o, doubler_delay_ns_o}, {d, dl[d]})
      `CHK(suspend_pin_o, sv & pid[5])
      `CHK({pll_enable_o, serial_bit_clock_force_in_o, frame_sync_force_in_o},
           sv ? pid[4:2] : 3'h0)
      `CHK(settings_valid_o, sv)
      if (md == 3) begin
        rom_req_i = 1'b1;
        mem_data_i = 8'hC3;
        repeat (4) @(negedge ref_clk_i);
        `CHK({rom_chip_select_n_o, mem_addr_oe_o}, 2'h1)
        `CHK({mem_addr_o, rom_data_o}, {5'h00, rom_address_i, 8'hC3})
        rom_req_i = 1'b0;
      end
    end
    wq = '{8'h11, 8'h22, 8'h33};
    vcmd(8'h40, 8'h00, 16'h0000, 16'h00E0, 8'h03);
    vcmd(8'hC0, 8'h02, 16'h0000, 16'h00E0, 8'h03);
    `CHK({rq[0], rq[1], rq[2]}, 24'h112233)
    wq = '{8'hA1, 8'hB2};
    vcmd(8'h40, 8'h05, 16'h0000, 16'h0040, 8'h02);
    vcmd(8'hC0, 8'h00, 16'h0000, 16'hAB40, 8'h02);
    `CHK({rq[0], rq[1]}, 16'hB21B)
    vcmd(8'hC0, 8'h0E, 16'hFFFE, 16'h00C8, 8'h05);
    `CHK(rq.size(), 2)
    `CHK({rq[0], rq[1], check_failed_o}, {16'h9293, 1'b1})
    wq = '{8'h77};
    vcmd(8'h40, 8'h00, 16'h0000, 16'h0005, 8'h01);
    `CHK(check_failed_o, 1'b0)
    vcmd(8'hC0, 8'h00, 16'h0000, 16'h0005, 8'h02);
    `CHK({rq[0], rq[1]}, 16'h0201)
    vcmd(8'hC0, 8'h00, 16'h0000, 16'h0010, 8'h00);
    `CHK(rq.size(), 0)
    vcmd(8'hC0, 8'h01, 16'h0000, 16'h5A10, 8'hFF);
    `CHK(rq.size(), 255)
    `CHK({rq[0], rq[254]}, 16'h4A4A)
    print_verdict();
  end
  initial begin
    #600us;
    errors++;
    print_verdict();
  end
endmodule // test_usb_vendor_cmd_and_strap_config
